// file: test_weigh_print_trigger_min_weight_check.sv
`timescale 1ns/1ns
// register and weight-sample call sequences against expected values
module test_weigh_print_trigger_min_weight_check import wptm_pkg::*;;
   logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, sv = 1'h0, nm = 1'h0, preq = 1'h0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [1:0] lvl = 2'h0, cnt;
   logic signed [23:0] gross = 24'h0, net = 24'h0;
   logic waitreq, fire, auto_o, refused, act, viol, icon, grey, hide;
   logic [2:0] seen;
   int mismatches = 0, compares = 0;
   always #25 clk = ~clk;
   wptm_top DUT (.CLOCK_I(clk), .SRST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF), .USER_LEVEL_I(lvl),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .SAMPLE_VALID_I(sv),
      .GROSS_WEIGHT_I(gross), .NET_WEIGHT_I(net), .NO_MOTION_I(nm), .PRINT_REQ_I(preq),
      .OUTPUT_FIRE_O(fire), .OUTPUT_AUTO_O(auto_o), .REQ_REFUSED_O(refused), .MW_ACTIVE_O(act),
      .MW_VIOLATION_O(viol), .MW_ICON_FLICKER_O(icon), .MW_WEIGHT_GREY_O(grey),
      .MW_WEIGHT_HIDE_O(hide));
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen_v, input logic [31:0] exp_v);
      compares++;
      if (seen_v !== exp_v) begin
         mismatches++;
         $display("[FAIL] %s expected %0h seen %0h", s, exp_v, seen_v);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge; data taken at that edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      input logic [1:0] l);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      lvl <= l;
      @(posedge clk);
      while (waitreq !== 1'h0 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) mismatches++;
      rv = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      bus(1'h1, a, d, USR_ADMIN);
   endtask
   task automatic rchk(input string s, input logic [5:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0, USR_ADMIN);
      chk(s, rv, e);
   endtask
   // demand latched a cycle ahead; pulses gathered over the two cycles after the sample
   task automatic smp(input logic p, input logic signed [23:0] g, input logic signed [23:0] n,
      input logic m);
      @(posedge clk);
      preq <= p;
      @(posedge clk);
      preq <= 1'h0;
      sv <= 1'h1;
      gross <= g;
      net <= n;
      nm <= m;
      @(posedge clk);
      sv <= 1'h0;
      seen = 3'h0;
      repeat (2) begin
         #1 seen = seen | {fire, auto_o, refused};
         @(posedge clk);
      end
   endtask
   // net held at zero so only gross can drive a trigger
   task automatic tst(input string s, input logic p, input logic signed [23:0] g, input logic m,
      input logic [2:0] e);
      smp(p, g, 24'h0, m);
      chk(s, seen, e);
   endtask
   task automatic mw(input string s, input logic [4:0] e);
      repeat (2) @(posedge clk);
      #1 chk(s, {act, viol, icon, grey, hide}, e);
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'h1;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
   endtask
   initial begin
      #200000;
      mismatches++;
      close_out();
   end
   initial begin
      do_reset();
      rchk("ctrl", OFS_CTRL, 32'h0);
      rchk("safety", OFS_SAFETY, 32'h1);
      rchk("tolerance", OFS_TOLERANCE, 32'h0);
      rchk("mw_cfg", OFS_MW_CFG, 32'h3);
      rchk("unmapped", 6'h28, 32'h0);
      bus(1'h0, OFS_STATUS, 32'h0, USR_ADMIN);
      chk("status", rv & 32'hF, 32'h3);
      // demand printing, interlock off
      wreg(OFS_MIN_WEIGHT, 32'h0);
      tst("zero gross", 1'h1, 24'h0, 1'h1, 3'h1);
      tst("negative", 1'h1, 24'hFFFFFB, 1'h1, 3'h1);
      wreg(OFS_MIN_WEIGHT, 32'h64);
      tst("below min", 1'h1, 24'h32, 1'h1, 3'h1);
      tst("demand ok", 1'h1, 24'hC8, 1'h1, 3'h4);
      tst("moving", 1'h1, 24'hC8, 1'h0, 3'h1);
      tst("no auto", 1'h0, 24'hC8, 1'h1, 3'h0);
      // interlock with return rearm
      wreg(OFS_CTRL, 32'h1);
      wreg(OFS_REARM, 32'h1E);
      // the earlier demand left the interlock spent, so meet the rearm point first
      tst("il arm", 1'h0, 24'h14, 1'h1, 3'h0);
      tst("il first", 1'h1, 24'hC8, 1'h1, 3'h4);
      tst("il repeat", 1'h1, 24'hC8, 1'h1, 3'h1);
      tst("il above", 1'h0, 24'h28, 1'h1, 3'h0);
      tst("il still", 1'h1, 24'hC8, 1'h1, 3'h1);
      tst("il low", 1'h0, 24'h14, 1'h1, 3'h0);
      tst("il rearmed", 1'h1, 24'hC8, 1'h1, 3'h4);
      // automatic, return rearm, then motion check
      do_reset();
      wreg(OFS_MIN_WEIGHT, 32'h64);
      wreg(OFS_THRESHOLD, 32'h12C);
      wreg(OFS_REARM, 32'h1E);
      wreg(OFS_CTRL, 32'h2);
      tst("under thr", 1'h0, 24'hFA, 1'h1, 3'h0);
      tst("auto moving", 1'h0, 24'h190, 1'h0, 3'h0);
      tst("auto fire", 1'h0, 24'h190, 1'h1, 3'h6);
      tst("auto repeat", 1'h0, 24'h190, 1'h1, 3'h0);
      tst("auto low", 1'h0, 24'h0A, 1'h0, 3'h0);
      tst("auto again", 1'h0, 24'h190, 1'h1, 3'h6);
      wreg(OFS_CTRL, 32'hA);
      tst("low moving", 1'h0, 24'h0A, 1'h0, 3'h0);
      tst("mc blocked", 1'h0, 24'h190, 1'h1, 3'h0);
      // deviation rearm ignores threshold
      do_reset();
      wreg(OFS_MIN_WEIGHT, 32'h64);
      wreg(OFS_THRESHOLD, 32'h12C);
      wreg(OFS_REARM, 32'h32);
      wreg(OFS_CTRL, 32'h6);
      tst("dev below thr", 1'h0, 24'h96, 1'h1, 3'h6);
      tst("dev small", 1'h0, 24'hB4, 1'h1, 3'h0);
      smp(1'h0, 24'hFA, 24'h0, 1'h1);
      cnt = {1'h0, seen[2]};
      smp(1'h0, 24'hFA, 24'h0, 1'h1);
      chk("dev large", cnt + seen[2], 32'h1);
      // minimum-weight check
      do_reset();
      smp(1'h0, 24'h32, 24'h32, 1'h1);
      mw("mw off", 5'h00);
      wreg(OFS_DET_MIN, 32'h14);
      wreg(OFS_SAFETY, 32'h3);
      rchk("factored", OFS_FACTORED, 32'h3C);
      wreg(OFS_FACTORED, 32'h99);
      rchk("factored ro", OFS_FACTORED, 32'h3C);
      mw("viol sf", 5'h1E);
      wreg(OFS_MW_CFG, 32'h2);
      mw("viol det", 5'h10);
      for (int b = 0; b < 3; b++) begin
         wreg(OFS_MW_CFG, 32'(b * 2 + 1));
         mw("behaviour", {3'h7, b == 1, b == 2});
      end
      wreg(OFS_MW_CFG, 32'h7);
      rchk("behav code", OFS_MW_CFG, 32'h5);
      wreg(OFS_SAFETY, 32'h0);
      wreg(OFS_SAFETY, 32'hB);
      rchk("sf range", OFS_SAFETY, 32'h3);
      wreg(OFS_SAFETY, 32'hA);
      rchk("sf max", OFS_SAFETY, 32'hA);
      wreg(OFS_TOLERANCE, 32'h65);
      rchk("tol range", OFS_TOLERANCE, 32'h0);
      wreg(OFS_TOLERANCE, 32'h64);
      rchk("tol max", OFS_TOLERANCE, 32'h64);
      bus(1'h1, OFS_DET_MIN, 32'h5, USR_OPERATOR);
      rchk("operator", OFS_DET_MIN, 32'h14);
      bus(1'h1, OFS_DET_MIN, 32'h0, USR_SUPERVISOR);
      rchk("supervisor", OFS_DET_MIN, 32'h0);
      mw("det zero", 5'h00);
      close_out();
   end
endmodule

// file: wptm_monitor.sv
`timescale 1ns/1ns
// relations between outputs and their causes, seen from the top ports only
module wptm_monitor import wptm_pkg::*; #(
   parameter int WGT_W = 24
) (
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic SAMPLE_VALID_I,
   input wire logic signed [WGT_W-1:0] GROSS_WEIGHT_I,
   input wire logic NO_MOTION_I,
   input wire logic OUTPUT_FIRE_O,
   input wire logic OUTPUT_AUTO_O,
   input wire logic REQ_REFUSED_O,
   input wire logic MW_ACTIVE_O,
   input wire logic MW_VIOLATION_O,
   input wire logic MW_ICON_FLICKER_O,
   input wire logic MW_WEIGHT_GREY_O,
   input wire logic MW_WEIGHT_HIDE_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // bus: at most one wait cycle, never stalled while idle
   one_wait_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
      |=> !AVS_WAITREQUEST_O)
      else $error("access waited more than one cycle");
   idle_ready_a: assert property (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
      else $error("waitrequest high while idle");
   // a fire only follows a settled positive sample one cycle earlier; a refusal only follows a sample and never comes with a fire
   fire_settled_a: assert property (OUTPUT_FIRE_O |->
      $past(SAMPLE_VALID_I) && $past(NO_MOTION_I))
      else $error("fire without settled sample");
   fire_positive_a: assert property (OUTPUT_FIRE_O |-> $past(GROSS_WEIGHT_I) > 0)
      else $error("fire at gross not above zero");
   auto_fire_a: assert property (OUTPUT_AUTO_O |-> OUTPUT_FIRE_O)
      else $error("auto pulse without fire");
   auto_twice_a: assert property (OUTPUT_AUTO_O |=> !OUTPUT_AUTO_O)
      else $error("auto fired twice without rearm");
   refuse_sample_a: assert property (REQ_REFUSED_O |->
      $past(SAMPLE_VALID_I) && !OUTPUT_FIRE_O)
      else $error("refusal outside a sample");
   // display flags hang off the violation
   viol_active_a: assert property (MW_VIOLATION_O |-> MW_ACTIVE_O)
      else $error("violation while check inactive");
   icon_viol_a: assert property (MW_ICON_FLICKER_O == MW_VIOLATION_O)
      else $error("icon differs from violation");
   grey_hide_a: assert property (MW_WEIGHT_GREY_O || MW_WEIGHT_HIDE_O |->
      MW_VIOLATION_O && !(MW_WEIGHT_GREY_O && MW_WEIGHT_HIDE_O))
      else $error("grey or hide without violation");
endmodule

bind wptm_top wptm_monitor #(.WGT_W(WGT_W)) u_mon (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .SAMPLE_VALID_I(SAMPLE_VALID_I), .GROSS_WEIGHT_I(GROSS_WEIGHT_I), .NO_MOTION_I(NO_MOTION_I),
   .OUTPUT_FIRE_O(OUTPUT_FIRE_O), .OUTPUT_AUTO_O(OUTPUT_AUTO_O), .REQ_REFUSED_O(REQ_REFUSED_O),
   .MW_ACTIVE_O(MW_ACTIVE_O), .MW_VIOLATION_O(MW_VIOLATION_O),
   .MW_ICON_FLICKER_O(MW_ICON_FLICKER_O), .MW_WEIGHT_GREY_O(MW_WEIGHT_GREY_O),
   .MW_WEIGHT_HIDE_O(MW_WEIGHT_HIDE_O));

// file: wptm_pkg.sv
package wptm_pkg;
   // register byte offsets on the avalon slave
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_MIN_WEIGHT = 6'h04;
   localparam logic [5:0] OFS_THRESHOLD = 6'h08;
   localparam logic [5:0] OFS_REARM = 6'h0C;
   localparam logic [5:0] OFS_DET_MIN = 6'h10;
   localparam logic [5:0] OFS_SAFETY = 6'h14;
   localparam logic [5:0] OFS_TOLERANCE = 6'h18;
   localparam logic [5:0] OFS_FACTORED = 6'h1C;
   localparam logic [5:0] OFS_STATUS = 6'h20;
   localparam logic [5:0] OFS_MW_CFG = 6'h24;
   // control register fields
   localparam int CTRL_INTERLOCK = 0;
   localparam int CTRL_AUTO = 1;
   localparam int CTRL_DEVIATION = 2;
   localparam int CTRL_MOTION_CHK = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // min-weight config fields
   localparam int MWC_SEL_FACTORED = 0;
   localparam int MWC_BEHAV_LSB = 1;
   // status fields
   localparam int ST_IL_ARMED = 0;
   localparam int ST_AUTO_ARMED = 1;
   localparam int ST_MW_ACTIVE = 2;
   localparam int ST_MW_VIOL = 3;
   localparam int ST_IL_REARM_MET = 4;
   localparam int ST_PEND = 5;
   // setting limits and reset values
   localparam logic [3:0] SAFETY_MIN = 4'h1;
   localparam logic [3:0] SAFETY_MAX = 4'hA;
   localparam logic [3:0] SAFETY_RESET = 4'h1;
   localparam logic [6:0] TOL_MAX = 7'h64;
   localparam logic [6:0] TOL_RESET = 7'h00;

   // violation display behaviour
   typedef enum logic [1:0] {
      BEHAV_ICON = 2'b00,
      BEHAV_GREY = 2'b01,
      BEHAV_HIDE = 2'b10
   } wptm_behav_e;
   localparam logic MWC_SEL_RESET = 1'b1;

   // user privilege levels presented with each bus access
   typedef enum logic [1:0] {
      USR_ADMIN = 2'b00,
      USR_SUPERVISOR = 2'b01,
      USR_OPERATOR = 2'b10
   } wptm_user_e;
endpackage

// file: wptm_top.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module wptm_top import wptm_pkg::*; #(
   parameter int WGT_W = 24
) (
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   input wire logic [5:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [1:0] USER_LEVEL_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic SAMPLE_VALID_I,
   input wire logic signed [WGT_W-1:0] GROSS_WEIGHT_I,
   input wire logic signed [WGT_W-1:0] NET_WEIGHT_I,
   input wire logic NO_MOTION_I,
   input wire logic PRINT_REQ_I,
   output logic OUTPUT_FIRE_O,
   output logic OUTPUT_AUTO_O,
   output logic REQ_REFUSED_O,
   output logic MW_ACTIVE_O,
   output logic MW_VIOLATION_O,
   output logic MW_ICON_FLICKER_O,
   output logic MW_WEIGHT_GREY_O,
   output logic MW_WEIGHT_HIDE_O
);
   localparam int FW = WGT_W + 4;

   // the factored product and the 32-bit bus word must both fit
   if (WGT_W < 8 || WGT_W > 28) begin : g_width_chk
      $error("wptm_top: WGT_W must lie in 8..28");
   end

   // bus slave state
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   // settings
   logic [3:0] ctrl_q, ctrl_d;
   logic [WGT_W-1:0] min_w_q, min_w_d, thr_q, thr_d, rearm_q, rearm_d, det_q, det_d;
   logic [3:0] sf_q, sf_d;
   logic [6:0] tol_q, tol_d;
   logic sel_fact_q, sel_fact_d;
   wptm_behav_e behav_q, behav_d;
   logic [FW-1:0] fact_q, fact_d;
   // trigger state
   logic il_armed_q, il_armed_d, il_met_q, il_met_d, auto_armed_q, auto_armed_d;
   logic pend_q, pend_d;
   logic signed [WGT_W-1:0] ref_q, ref_d;
   logic fire_q, fire_d, auto_q, auto_d, refused_q, refused_d;
   logic viol_q, viol_d, active_q, active_d;

   logic req, wr_en, mw_wr_ok;
   logic [31:0] mask, cur_word, wword;
   logic signed [WGT_W:0] gross_x, min_x, thr_x, rearm_x, diff, adiff;
   logic above_min, above_zero, settled, rearm_hit, dev_mode;
   logic auto_go, demand_go, any_go, il_ready;
   logic signed [FW:0] net_x, mw_thr_x;

   // one wait cycle per access: data is prepared, then waitrequest drops
   assign req = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req & ~ack_q;
   assign wr_en = AVS_WRITE_I & ack_q;
   assign mw_wr_ok = (USER_LEVEL_I == USR_ADMIN) || (USER_LEVEL_I == USR_SUPERVISOR);
   assign mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                  {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
   assign wword = (cur_word & ~mask) | (AVS_WRITEDATA_I & mask);

   // register read mux; unmapped offsets read as zero
   always_comb begin
      cur_word = 32'h0000_0000;
      case (AVS_ADDRESS_I & 6'h3C)
         OFS_CTRL: cur_word = {28'h000_0000, ctrl_q};
         OFS_MIN_WEIGHT: cur_word = 32'(min_w_q);
         OFS_THRESHOLD: cur_word = 32'(thr_q);
         OFS_REARM: cur_word = 32'(rearm_q);
         OFS_DET_MIN: cur_word = 32'(det_q);
         OFS_SAFETY: cur_word = {28'h000_0000, sf_q};
         OFS_TOLERANCE: cur_word = {25'h000_0000, tol_q};
         OFS_FACTORED: cur_word = 32'(fact_q);
         OFS_STATUS: cur_word = {26'h000_0000, pend_q, il_met_q, viol_q, active_q,
                                 auto_armed_q, il_armed_q};
         OFS_MW_CFG: cur_word = {29'h0000_0000, behav_q, sel_fact_q};
         default: cur_word = 32'h0000_0000;
      endcase
   end

   // bus handshake and register writes
   always_comb begin
      ack_d = req & ~ack_q;
      rdata_d = rdata_q;
      if (AVS_READ_I && !ack_q) begin
         rdata_d = cur_word;
      end
      ctrl_d = ctrl_q;
      min_w_d = min_w_q;
      thr_d = thr_q;
      rearm_d = rearm_q;
      det_d = det_q;
      sf_d = sf_q;
      tol_d = tol_q;
      sel_fact_d = sel_fact_q;
      behav_d = behav_q;
      if (wr_en) begin
         case (AVS_ADDRESS_I & 6'h3C)
            OFS_CTRL: ctrl_d = wword[3:0];
            OFS_MIN_WEIGHT: min_w_d = wword[WGT_W-1:0];
            OFS_THRESHOLD: thr_d = wword[WGT_W-1:0];
            OFS_REARM: rearm_d = wword[WGT_W-1:0];
            OFS_DET_MIN: begin
               if (mw_wr_ok) begin
                  det_d = wword[WGT_W-1:0];
               end
            end
            OFS_SAFETY: begin
               // out-of-range factors are dropped, old value kept
               if (mw_wr_ok && wword[31:4] == 28'h000_0000 && wword[3:0] >= SAFETY_MIN
                   && wword[3:0] <= SAFETY_MAX) begin
                  sf_d = wword[3:0];
               end
            end
            OFS_TOLERANCE: begin
               if (mw_wr_ok && wword[31:7] == 25'h000_0000 && wword[6:0] <= TOL_MAX) begin
                  tol_d = wword[6:0];
               end
            end
            OFS_MW_CFG: begin
               // code 2'b11 names no behaviour and is refused
               if (mw_wr_ok && wword[2:1] != 2'b11) begin
                  sel_fact_d = wword[MWC_SEL_FACTORED];
                  behav_d = wptm_behav_e'(wword[2:1]);
               end
            end
            default: ctrl_d = ctrl_q;
         endcase
      end
      fact_d = FW'(det_q) * FW'(sf_q);
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         ctrl_q <= CTRL_RESET;
         min_w_q <= '0;
         thr_q <= '0;
         rearm_q <= '0;
         det_q <= '0;
         sf_q <= SAFETY_RESET;
         tol_q <= TOL_RESET;
         sel_fact_q <= MWC_SEL_RESET;
         behav_q <= BEHAV_GREY;
         fact_q <= '0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         ctrl_q <= ctrl_d;
         min_w_q <= min_w_d;
         thr_q <= thr_d;
         rearm_q <= rearm_d;
         det_q <= det_d;
         sf_q <= sf_d;
         tol_q <= tol_d;
         sel_fact_q <= sel_fact_d;
         behav_q <= behav_d;
         fact_q <= fact_d;
      end
   end
   assign AVS_READDATA_O = rdata_q;

   // weight comparisons, all on gross weight
   assign gross_x = {GROSS_WEIGHT_I[WGT_W-1], GROSS_WEIGHT_I};
   assign min_x = $signed({1'b0, min_w_q});
   assign thr_x = $signed({1'b0, thr_q});
   assign rearm_x = $signed({1'b0, rearm_q});
   assign dev_mode = ctrl_q[CTRL_DEVIATION];
   assign settled = NO_MOTION_I;
   assign above_min = gross_x >= min_x;
   assign above_zero = gross_x > 0;
   assign diff = gross_x - $signed({ref_q[WGT_W-1], ref_q});
   assign adiff = diff[WGT_W] ? -diff : diff;
   // motion check only applies in return mode
   always_comb begin
      if (dev_mode) begin
         rearm_hit = adiff > rearm_x;
      end else begin
         rearm_hit = (gross_x < rearm_x) &&
                     !(ctrl_q[CTRL_MOTION_CHK] && !settled);
      end
   end
   // the threshold is ignored in deviation mode
   assign auto_go = ctrl_q[CTRL_AUTO] && auto_armed_q && settled && above_zero && above_min
                    && (dev_mode || gross_x > thr_x);
   // the sample that settles above minimum after the rearm event may itself print
   assign il_ready = il_armed_q
                     || ((il_met_q || rearm_hit) && settled && gross_x > min_x);
   assign demand_go = pend_q && settled && above_zero && above_min
                      && (!ctrl_q[CTRL_INTERLOCK] || il_ready);
   assign any_go = auto_go || demand_go;

   // trigger state, evaluated once per weight sample
   always_comb begin
      il_armed_d = il_armed_q;
      il_met_d = il_met_q;
      auto_armed_d = auto_armed_q;
      ref_d = ref_q;
      pend_d = pend_q | PRINT_REQ_I;
      fire_d = 1'b0;
      auto_d = 1'b0;
      refused_d = 1'b0;
      if (SAMPLE_VALID_I) begin
         // a demand waits for the next sample; a request in this cycle survives
         pend_d = PRINT_REQ_I;
         refused_d = pend_q && !demand_go && !auto_go;
         if (any_go) begin
            fire_d = 1'b1;
            auto_d = auto_go;
            ref_d = GROSS_WEIGHT_I;
            il_armed_d = 1'b0;
            il_met_d = 1'b0;
            if (auto_go) begin
               auto_armed_d = 1'b0;
            end
         end else begin
            if (rearm_hit) begin
               auto_armed_d = 1'b1;
               il_met_d = 1'b1;
            end
            // interlock also waits for a settled weight above minimum
            if ((il_met_q || rearm_hit) && settled && gross_x > min_x) begin
               il_armed_d = 1'b1;
            end
         end
      end
   end

   // min-weight check on net weight
   assign net_x = (FW + 1)'(NET_WEIGHT_I);
   assign mw_thr_x = $signed({1'b0, (sel_fact_q ? fact_q : FW'(det_q))});
   always_comb begin
      active_d = det_q != '0;
      viol_d = active_d && (net_x < mw_thr_x);
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         il_armed_q <= 1'b1;
         il_met_q <= 1'b0;
         auto_armed_q <= 1'b1;
         pend_q <= 1'b0;
         ref_q <= '0;
         fire_q <= 1'b0;
         auto_q <= 1'b0;
         refused_q <= 1'b0;
         viol_q <= 1'b0;
         active_q <= 1'b0;
      end else begin
         il_armed_q <= il_armed_d;
         il_met_q <= il_met_d;
         auto_armed_q <= auto_armed_d;
         pend_q <= pend_d;
         ref_q <= ref_d;
         fire_q <= fire_d;
         auto_q <= auto_d;
         refused_q <= refused_d;
         viol_q <= viol_d;
         active_q <= active_d;
      end
   end

   // display controls follow the registered violation flag
   assign OUTPUT_FIRE_O = fire_q;
   assign OUTPUT_AUTO_O = auto_q;
   assign REQ_REFUSED_O = refused_q;
   assign MW_ACTIVE_O = active_q;
   assign MW_VIOLATION_O = viol_q;
   assign MW_ICON_FLICKER_O = viol_q;
   assign MW_WEIGHT_GREY_O = viol_q && (behav_q == BEHAV_GREY);
   assign MW_WEIGHT_HIDE_O = viol_q && (behav_q == BEHAV_HIDE);
endmodule
